// ---- cpsi_map.vh ----
`ifndef CPSI_MAP_VH
`define CPSI_MAP_VH

// Register byte offsets on the APB slave
`define REG_TEST          8'h00
`define REG_STATUS        8'h04
`define REG_COINC         8'h08
`define REG_WIDE          8'h0c

// Test register fields and reset values
`define TEST_SI_LSB       0
`define TEST_CDA_LSB      8
`define TEST_TRAIN_LSB    16
`define TEST_SI_RST       8'h00
`define TEST_CDA_RST      5'h00
`define TEST_TRAIN_RST    2'h0

// Status register bits, one byte per train
`define STAT_STRIDE       8
`define STAT_SI           0
`define STAT_CDA          1
`define STAT_PHASE_A      2
`define STAT_PHASE_B      3
`define STAT_STEAM_ISO    4
`define STAT_RECIRC       5
`define STAT_TIME_UP      6

// Coincidence register bits, one byte per train
`define COINC_HI          0
`define COINC_IHH         1
`define COINC_HH          2
`define COINC_SI_AUTO     3

// Wide range indication, second channel position
`define WIDE_B_LSB        16

// Timing
`define CLK_HZ            20000000
`define SI_RESET_DELAY_S  60

`endif

// ---- sync_2ff.v ----
`timescale 1ns/1ps

module sync_2ff #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         nrst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// First stage feeds only the second stage
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule // sync_2ff

// ---- act_latch.v ----
`timescale 1ns/1ps

module act_latch #(
	parameter N = 1
) (
	input  wire         mclk,
	input  wire         nrst,
	input  wire         set,
	input  wire         clr,
	input  wire [N-1:0] permit,
	input  wire [N-1:0] test,
	output wire         master,
	output wire [N-1:0] slave
);

	reg         master_ff;
	reg [N-1:0] slave_ff;
	wire        nxt_master;

	// Set wins over clear, so an early or stuck reset never masks a real demand
	assign nxt_master = set | (master_ff & ~clr);

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			master_ff <= 1'b0;
			slave_ff  <= {N{1'b0}};
		end else begin
			master_ff <= nxt_master;
			slave_ff  <= ({N{master_ff}} & permit) | test;
		end
	end

	assign master = master_ff;
	assign slave  = slave_ff;

endmodule // act_latch

// ---- containment_pressure_si_actuation.v ----
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "cpsi_map.vh"


module containment_pressure_si_actuation #(
	parameter        WIDE_W          = 12,
	parameter [31:0] SI_RESET_CYCLES = `SI_RESET_DELAY_S * `CLK_HZ
) (
	input  wire              mclk,
	input  wire              nrst,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output wire [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	input  wire [2:0]        hiTripN,
	input  wire [2:0]        ihhTripN,
	input  wire [3:0]        hhTrip,
	input  wire [2:0]        hiTestOpen,
	input  wire [2:0]        ihhTestOpen,
	input  wire [3:0]        hhTestClosed,
	input  wire [1:0]        manSpray,
	input  wire [1:0]        manSi,
	input  wire [2:0]        hiSteamFlow,
	input  wire [2:0]        lowSteamPress,
	input  wire [2:0]        lowLowTavg,
	input  wire              hiSteamDp,
	input  wire              lowLowPzrPress,
	input  wire [3:0]        tankLow,
	input  wire [1:0]        siNormalOrClearSelector,
	input  wire [1:0]        sprayNormalOrClearSelector,
	input  wire [1:0]        tripBreakersOpen,
	input  wire [WIDE_W-1:0] widePressA,
	input  wire [WIDE_W-1:0] widePressB,
	output wire [1:0]        safeguardsActuationMaster,
	output wire [15:0]       safeguardsActuationSlave,
	output wire [1:0]        containmentDepressActuationMaster,
	output wire [9:0]        containmentDepressActuationSlave,
	output wire [1:0]        phaseA,
	output wire [1:0]        phaseB,
	output wire [1:0]        steamIso,
	output wire [1:0]        recircSpray
);

	localparam NTRAIN = 2;
	localparam IN_W   = 42;

	reg  [7:0]        testSi_ff;
	reg  [4:0]        testCda_ff;
	reg  [1:0]        testTrain_ff;
	reg  [31:0]       prdata_ff;
	reg               pready_ff;
	reg               pslverr_ff;
	reg  [WIDE_W-1:0] wideA_ff;
	reg  [WIDE_W-1:0] wideB_ff;
	reg  [31:0]       nxt_prdata;
	reg               addrHit;
	wire              setupPhase;
	wire              wrEn;
	wire [15:0]       statusW;
	wire [15:0]       coincW;
	wire [38:0]       sharedIn;

	function twoOfThree;
		input [2:0] v;
		begin
			twoOfThree = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
		end
	endfunction

	function twoOfFour;
		input [3:0] v;
		begin
			twoOfFour = (v[0] & (v[1] | v[2] | v[3])) | (v[1] & (v[2] | v[3])) | (v[2] & v[3]);
		end
	endfunction

	function threeOfFour;
		input [3:0] v;
		begin
			threeOfFour = (v[0] & v[1] & v[2]) | (v[0] & v[1] & v[3]) |
				(v[0] & v[2] & v[3]) | (v[1] & v[2] & v[3]);
		end
	endfunction

	// Active-low trips are inverted ahead of the synchroniser so its zero reset reads as idle, not tripped
	assign sharedIn = {tankLow, lowLowPzrPress, hiSteamDp, lowLowTavg, lowSteamPress, hiSteamFlow,
		manSi, manSpray, hhTestClosed, ihhTestOpen, hiTestOpen, hhTrip, ~ihhTripN, ~hiTripN};

	genvar t;
	generate
		for (t = 0; t < NTRAIN; t = t + 1) begin : train
			// Each train keeps its own synchroniser so a fault in one cannot reach the other
			wire [IN_W-1:0] inBus;
			wire [IN_W-1:0] s;
			wire [2:0]      hiAct;
			wire [2:0]      ihhAct;
			wire [3:0]      hhAct;
			wire            hiSig;
			wire            ihhSig;
			wire            hhSig;
			wire            siAuto;
			wire            siSet;
			wire            cdaSet;
			wire            siTimeUp;
			wire            siClr;
			wire            cdaClr;
			wire            rsSet;
			wire [7:0]      siTest;
			wire [4:0]      cdaTest;
			wire [4:0]      cdaPermit;
			reg  [31:0]     siCnt_ff;
			reg  [1:0]      selPrev_ff;

			assign inBus = {tripBreakersOpen[t], sprayNormalOrClearSelector[t],
				siNormalOrClearSelector[t], sharedIn};

			sync_2ff #(
				.W (IN_W)
			) uSync (
				.mclk (mclk),
				.nrst (nrst),
				.d    (inBus),
				.q    (s)
			);

			assign hiAct  = s[2:0];
			assign ihhAct = s[5:3];
			assign hhAct  = s[9:6] & s[19:16];

			assign hiSig  = twoOfThree(hiAct) | twoOfThree(s[12:10]);
			assign ihhSig = twoOfThree(ihhAct) | twoOfThree(s[15:13]);
			assign hhSig  = twoOfFour(hhAct);

			// Steam-line break and pressurizer causes, plus high containment pressure
			assign siAuto = (twoOfThree(s[26:24]) & (twoOfThree(s[29:27]) | twoOfThree(s[32:30]))) |
				s[33] | s[34] | hiSig;
			assign siSet  = siAuto | (|s[23:22]);
			assign cdaSet = (&s[21:20]) | hhSig;
			assign rsSet  = threeOfFour(s[38:35]) & hhSig;

			// Timer starts with the latched injection and saturates at the delay
			assign siTimeUp = (siCnt_ff == SI_RESET_CYCLES);

			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					siCnt_ff <= 32'h0;
				end else if (!safeguardsActuationMaster[t]) begin
					siCnt_ff <= 32'h0;
				end else if (!siTimeUp) begin
					siCnt_ff <= siCnt_ff + 32'h1;
				end
			end

			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					selPrev_ff <= 2'h0;
				end else begin
					selPrev_ff <= {s[40], s[39]};
				end
			end

			// Only a turn to clear counts; a selector left there beforehand does nothing
			assign siClr  = s[39] & ~selPrev_ff[0] & s[41] & siTimeUp;
			assign cdaClr = s[40] & ~selPrev_ff[1];

			assign siTest    = testTrain_ff[t] ? testSi_ff : 8'h00;
			assign cdaTest   = testTrain_ff[t] ? testCda_ff : 5'h00;
			assign cdaPermit = {3'h7, recircSpray[t], 1'b1};

			act_latch #(
				.N (8)
			) uSi (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (siSet),
				.clr    (siClr),
				.permit (8'hff),
				.test   (siTest),
				.master (safeguardsActuationMaster[t]),
				.slave  (safeguardsActuationSlave[t*8+7:t*8])
			);

			act_latch #(
				.N (5)
			) uCda (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (cdaSet),
				.clr    (cdaClr),
				.permit (cdaPermit),
				.test   (cdaTest),
				.master (containmentDepressActuationMaster[t]),
				.slave  (containmentDepressActuationSlave[t*5+4:t*5])
			);

			act_latch #(
				.N (1)
			) uPhaseA (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (siSet),
				.clr    (siClr),
				.permit (1'b1),
				.test   (1'b0),
				.master (phaseA[t]),
				.slave  ()
			);

			// Phase B follows high-high only, never the manual spray switches
			act_latch #(
				.N (1)
			) uPhaseB (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (hhSig),
				.clr    (cdaClr),
				.permit (1'b1),
				.test   (1'b0),
				.master (phaseB[t]),
				.slave  ()
			);

			act_latch #(
				.N (1)
			) uSteamIso (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (ihhSig),
				.clr    (siClr),
				.permit (1'b1),
				.test   (1'b0),
				.master (steamIso[t]),
				.slave  ()
			);

			act_latch #(
				.N (1)
			) uRecirc (
				.mclk   (mclk),
				.nrst   (nrst),
				.set    (rsSet),
				.clr    (cdaClr),
				.permit (1'b1),
				.test   (1'b0),
				.master (recircSpray[t]),
				.slave  ()
			);

			assign statusW[t*8+7:t*8] = {1'b0, siTimeUp, recircSpray[t], steamIso[t], phaseB[t], phaseA[t],
				containmentDepressActuationMaster[t], safeguardsActuationMaster[t]};
			assign coincW[t*8+7:t*8] = {4'h0, siAuto, hhSig, ihhSig, hiSig};
		end
	endgenerate

	// Wide range values are only sampled for readback
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wideA_ff <= {WIDE_W{1'b0}};
			wideB_ff <= {WIDE_W{1'b0}};
		end else begin
			wideA_ff <= widePressA;
			wideB_ff <= widePressB;
		end
	end

	assign setupPhase = psel & ~penable;
	assign wrEn       = psel & penable & pready_ff & pwrite;

	always @* begin
		nxt_prdata = 32'h0;
		addrHit    = 1'b1;
		case (paddr)
			`REG_TEST: begin
				nxt_prdata = {14'h0, testTrain_ff, 3'h0, testCda_ff, testSi_ff};
			end
			`REG_STATUS: begin
				nxt_prdata = {16'h0, statusW};
			end
			`REG_COINC: begin
				nxt_prdata = {16'h0, coincW};
			end
			`REG_WIDE: begin
				nxt_prdata = {{(16-WIDE_W){1'b0}}, wideB_ff, {(16-WIDE_W){1'b0}}, wideA_ff};
			end
			default: begin
				addrHit = 1'b0;
			end
		endcase
	end

	// Zero wait states: data and ready are set up during the setup cycle
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= setupPhase;
			pslverr_ff <= setupPhase & ~addrHit;
			if (setupPhase) begin
				prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
			end
		end
	end

	// Test masks can only add slave outputs, never suppress a real demand
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			testSi_ff    <= `TEST_SI_RST;
			testCda_ff   <= `TEST_CDA_RST;
			testTrain_ff <= `TEST_TRAIN_RST;
		end else if (wrEn && (paddr == `REG_TEST)) begin
			testSi_ff    <= pwdata[`TEST_SI_LSB+7:`TEST_SI_LSB];
			testCda_ff   <= pwdata[`TEST_CDA_LSB+4:`TEST_CDA_LSB];
			testTrain_ff <= pwdata[`TEST_TRAIN_LSB+1:`TEST_TRAIN_LSB];
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

endmodule // containment_pressure_si_actuation

// ---- cpsi_monitor.sv ----
`timescale 1ns/1ps
module cpsi_monitor (
	input wire        mclk,
	input wire        nrst,
	input wire        pslverr,
	input wire [2:0]  hiTripN,
	input wire [2:0]  ihhTripN,
	input wire [3:0]  hhTrip,
	input wire [3:0]  hhTestClosed,
	input wire [1:0]  manSi,
	input wire [1:0]  tripBreakersOpen,
	input wire [1:0]  siNormalOrClearSelector,
	input wire [1:0]  safeguardsActuationMaster,
	input wire [15:0] safeguardsActuationSlave,
	input wire [1:0]  containmentDepressActuationMaster,
	input wire [9:0]  containmentDepressActuationSlave,
	input wire [1:0]  phaseA,
	input wire [1:0]  phaseB,
	input wire [1:0]  steamIso,
	input wire [1:0]  recircSpray
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Coincidence seen at the pins; the design adds two sync stages and a latch stage
	wire       hiTwo  = $countones(~hiTripN) >= 2;
	wire       ihhTwo = $countones(~ihhTripN) >= 2;
	wire       hhTwo  = $countones(hhTrip & hhTestClosed) >= 2;
	wire [1:0] siM    = safeguardsActuationMaster;
	wire [1:0] cdaM   = containmentDepressActuationMaster;
	wire       selA   = siNormalOrClearSelector[0];

	property p_hh_cda; hhTwo |-> ##3 cdaM == 2'b11; endproperty
	a_hh_cda: assert property (p_hh_cda) else $error("no depress after high-high");
	property p_hi_si; hiTwo |-> ##3 siM == 2'b11; endproperty
	a_hi_si: assert property (p_hi_si) else $error("no injection after high");
	property p_ihh_iso; ihhTwo |-> ##3 steamIso == 2'b11; endproperty
	a_ihh_iso: assert property (p_ihh_iso) else $error("no steam isolation");
	property p_man_si; (|manSi) |-> ##3 siM == 2'b11; endproperty
	a_man_si: assert property (p_man_si) else $error("manual injection ignored");
	property p_phase_b; hhTwo |-> ##3 phaseB == 2'b11; endproperty
	a_phase_b: assert property (p_phase_b) else $error("phase B missing after high-high");
	property p_phase_b_cda; (phaseB & ~cdaM) == 2'b00; endproperty
	a_phase_b_cda: assert property (p_phase_b_cda) else $error("phase B without depress");
	property p_phase_a; phaseA == siM; endproperty
	a_phase_a: assert property (p_phase_a) else $error("phase A apart from injection");
	property p_si_fan; $rose(siM[0]) |=> safeguardsActuationSlave[7:0] == 8'hff; endproperty
	a_si_fan: assert property (p_si_fan) else $error("injection slaves missing");
	property p_cda_fan; $rose(cdaM[0]) |=> (containmentDepressActuationSlave[4:0] | 5'h02) == 5'h1f; endproperty
	a_cda_fan: assert property (p_cda_fan) else $error("depress slaves missing");
	property p_si_clr; $fell(siM[0]) |-> $past(selA, 3) && !$past(selA, 4) && $past(tripBreakersOpen[0], 3); endproperty
	a_si_clr: assert property (p_si_clr) else $error("injection dropped unqualified");
	property p_recirc; recircSpray[0] |-> cdaM[0]; endproperty
	a_recirc: assert property (p_recirc) else $error("recirc without depress");

	c_si_clr: cover property ($fell(siM[0]));
	c_recirc: cover property ($rose(recircSpray[0]));
	c_err: cover property (pslverr);
endmodule // cpsi_monitor

bind containment_pressure_si_actuation cpsi_monitor mon_u (.*);

// ---- chan_model.sv ----
`timescale 1ns/1ps
module chan_model (
	input  wire        mclk,
	input  wire        nrst,
	input  wire [2:0]  hiReq,
	input  wire [2:0]  ihhReq,
	output logic [2:0] hiTripN,
	output logic [2:0] ihhTripN
);
	// Input relays sit energized while healthy, so a trip or a lost channel reads low
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hiTripN  <= 3'h7;
			ihhTripN <= 3'h7;
		end else begin
			hiTripN  <= ~hiReq;
			ihhTripN <= ~ihhReq;
		end
	end
endmodule // chan_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, hiSteamDp, lowLowPzrPress, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  hiReq, ihhReq, hiTripN, ihhTripN, hiTestOpen, ihhTestOpen, hiSteamFlow, lowSteamPress, lowLowTavg;
	logic [3:0]  hhTrip, hhTestClosed, tankLow;
	logic [1:0]  manSpray, manSi, siSel, spSel, brk, siM, cdaM, phA, phB, sIso, rsp;
	logic [15:0] siS;
	logic [9:0]  cdaS;
	logic [11:0] wA, wB;
	int          num_errors, num_checks, cyc;

	chan_model chan_u (.mclk(mclk), .nrst(nrst), .hiReq(hiReq), .ihhReq(ihhReq), .hiTripN(hiTripN), .ihhTripN(ihhTripN));
	// Short reset delay keeps the one-minute wait to 20 cycles
	containment_pressure_si_actuation #(.SI_RESET_CYCLES(32'd20)) dut_u (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hiTripN(hiTripN), .ihhTripN(ihhTripN), .hhTrip(hhTrip), .hiTestOpen(hiTestOpen),
		.ihhTestOpen(ihhTestOpen), .hhTestClosed(hhTestClosed), .manSpray(manSpray), .manSi(manSi),
		.hiSteamFlow(hiSteamFlow), .lowSteamPress(lowSteamPress), .lowLowTavg(lowLowTavg), .hiSteamDp(hiSteamDp),
		.lowLowPzrPress(lowLowPzrPress), .tankLow(tankLow), .siNormalOrClearSelector(siSel),
		.sprayNormalOrClearSelector(spSel), .tripBreakersOpen(brk), .widePressA(wA), .widePressB(wB),
		.safeguardsActuationMaster(siM), .safeguardsActuationSlave(siS), .containmentDepressActuationMaster(cdaM),
		.containmentDepressActuationSlave(cdaS), .phaseA(phA), .phaseB(phB), .steamIso(sIso), .recircSpray(rsp));

	task tally_and_finish;
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Values read right at an edge are those settled before it
	task step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Clears act on the selector edge, so it is returned to normal afterwards
	task clr(input logic sp, input logic [1:0] m);
		@(posedge mclk);
		if (sp) spSel <= m; else siSel <= m;
		step(5);
		if (sp) spSel <= 2'b00; else siSel <= 2'b00;
		step(3);
	endtask

	task s_regs;
		apb(0, 8'h04, 0); chk(rd, 32'h0);
		apb(1, 8'h00, 32'h000100ff); apb(0, 8'h00, 0); chk(rd, 32'h000100ff);
		chk(siS, 16'h00ff); chk(siM, 2'b00);
		apb(1, 8'h00, 0); apb(0, 8'h10, 0); chk(rd, 32'h0); chk({31'h0, err}, 32'h1);
		@(posedge mclk) begin wA <= 12'h5a5; wB <= 12'h3c3; end
		apb(0, 8'h0c, 0); chk(rd, 32'h03c305a5); chk({siM, cdaM, sIso}, 6'h0);
	endtask
	task s_ihh;
		@(posedge mclk) ihhReq <= 3'b011;
		step(6); chk(sIso, 2'b11); chk(siM, 2'b00);
		@(posedge mclk) ihhReq <= 3'b000;
	endtask
	task s_hi;
		@(posedge mclk) hiReq <= 3'b001;
		step(6); chk(siM, 2'b00);
		@(posedge mclk) hiReq <= 3'b101;
		step(6);
		@(posedge mclk) hiReq <= 3'b000;
		step(6); chk(siM, 2'b11); chk(phA, 2'b11); chk(siS, 16'hffff); chk(cdaM, 2'b00);
		apb(0, 8'h04, 0); chk(rd[5:0] & 6'h3f, 6'h15);
	endtask
	task s_clear;
		clr(0, 2'b11); chk(siM, 2'b11);
		@(posedge mclk) brk <= 2'b11;
		clr(0, 2'b01); chk(siM, 2'b10);
		clr(0, 2'b10); chk({siM, phA, sIso}, 6'h0); chk(siS, 16'h0);
	endtask
	task s_man;
		@(posedge mclk) begin siSel <= 2'b11; manSi <= 2'b01; end
		step(6);
		@(posedge mclk) begin manSi <= 2'b00; siSel <= 2'b00; end
		step(3); chk(siM, 2'b11);
		clr(0, 2'b11); chk(siM, 2'b11);
		step(20); clr(0, 2'b11); chk(siM, 2'b00);
		@(posedge mclk) manSpray <= 2'b01;
		step(6); chk(cdaM, 2'b00);
		@(posedge mclk) manSpray <= 2'b11;
		step(6);
		@(posedge mclk) manSpray <= 2'b00;
		step(6); chk({cdaM, phB}, 4'hc);
		clr(1, 2'b11); chk(cdaM, 2'b00);
	endtask
	task s_hh;
		@(posedge mclk) begin hhTrip <= 4'b0011; hhTestClosed <= 4'b1110; tankLow <= 4'b0011; end
		step(6); chk(cdaM, 2'b00);
		@(posedge mclk) hhTestClosed <= 4'hf;
		step(6); chk({cdaM, phB, rsp, siM}, 8'hf0); chk(cdaS, 10'h3bd);
		apb(0, 8'h08, 0); chk(rd, 32'h00000404);
		@(posedge mclk) tankLow <= 4'b0111;
		step(6); chk(rsp, 2'b11); chk(cdaS, 10'h3ff);
		@(posedge mclk) begin hhTrip <= 4'h0; tankLow <= 4'h0; end
		step(6); chk({cdaM, rsp}, 4'hf);
		clr(1, 2'b11); chk({cdaM, phB, rsp}, 6'h0);
	endtask
	task s_auto;
		for (int k = 0; k < 6; k++) begin
			@(posedge mclk) begin
				hiTestOpen <= (k == 0) ? 3'b011 : 3'b000;
				ihhTestOpen <= (k == 0) ? 3'b110 : 3'b000;
				hiSteamFlow <= (k == 1) ? 3'b011 : (k == 2) ? 3'b101 : (k == 5) ? 3'b110 : 3'b000;
				lowSteamPress <= (k == 1) ? 3'b110 : 3'b000;
				lowLowTavg <= (k == 2) ? 3'b011 : 3'b000;
				hiSteamDp <= (k == 3);
				lowLowPzrPress <= (k == 4);
			end
			step(6);
			@(posedge mclk) begin hiTestOpen <= 0; ihhTestOpen <= 0; hiSteamFlow <= 0; lowSteamPress <= 0; lowLowTavg <= 0;
				hiSteamDp <= 0; lowLowPzrPress <= 0; end
			step(6); chk(siM, (k < 5) ? 2'b11 : 2'b00);
			chk(sIso, (k == 0) ? 2'b11 : 2'b00);
			step(20); clr(0, 2'b11);
		end
	endtask

	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, hiReq, ihhReq, hiTestOpen, ihhTestOpen} = 0;
		{hiSteamFlow, lowSteamPress, lowLowTavg, hiSteamDp, lowLowPzrPress, hhTrip, tankLow} = 0;
		{manSpray, manSi, siSel, spSel, brk, wA, wB} = 0;
		hhTestClosed = 4'hf;
		step(8);
		nrst <= 1'b1;
		s_regs;
		s_ihh;
		s_hi;
		s_clear;
		s_man;
		s_hh;
		s_auto;
		tally_and_finish;
	end
endmodule // tb_top
